// ==== dv/i2c_io_expander_core_tb_top.sv ====
`timescale 1ns/1ps
module i2c_io_expander_core_tb_top;
  localparam int AC = 8;
  logic sys_clk, rst, resetN, porOk, addrSel, scl, sdaLow, sdaOe, sdaOut, alertNOe, alertNOut;
  logic [15:0] ext, pins, ioPinsOut, ioPinsOe, pu, pd;
  logic [6:0] tgt;
  int nFail, numChecks;
  wire logic sdaLine = !(sdaLow || sdaOe);
  wire logic alertLine = alertNOe ? alertNOut : 1'b1;
  assign pins = (ioPinsOe & ioPinsOut) | (~ioPinsOe & ext);
  i2c_io_expander_core #(.ALERT_CYCLES(AC)) dut (
    .sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .resetN(resetN), .powerOnThresholdOk(porOk),
    .addrSel(addrSel), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .ioPinsIn(pins), .ioPinsOut(ioPinsOut), .ioPinsOe(ioPinsOe), .pullUpTransistor(pu),
    .pullDownTransistor(pd), .alertNOut(alertNOut), .alertNOe(alertNOe));
  i2c_master_model mst (.sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic tx(input logic [7:0] b, input logic ea);
    logic [7:0] q;
    logic a;
    mst.xfer(b, 1'b1, q, a);
    chk(a, ea);
  endtask : tx
  task automatic wr(input logic [2:0] c, input logic [15:0] d);
    mst.start();
    tx({tgt, 1'b0}, 1'b0);
    tx({5'h00, c}, 1'b0);
    tx(d[7:0], 1'b0);
    tx(d[15:8], 1'b0);
    mst.stop();
    cyc(2);
  endtask : wr
  // Second byte comes from the other register of the pair
  task automatic rc(input logic [2:0] c, input logic [15:0] e);
    logic [15:0] d;
    logic a;
    mst.start();
    tx({tgt, 1'b0}, 1'b0);
    tx({5'h00, c}, 1'b0);
    mst.start();
    tx({tgt, 1'b1}, 1'b0);
    mst.xfer(8'hff, 1'b0, d[7:0], a);
    mst.xfer(8'hff, 1'b1, d[15:8], a);
    chk(sdaOe, 1'b0);
    mst.stop();
    chk(d, e);
    cyc(2);
  endtask : rc
  task automatic foreign();
    mst.start();
    tx({7'h22, 1'b1}, 1'b1);
    mst.stop();
    cyc(2);
  endtask : foreign
  initial begin
    rst = 1'b1;
    resetN = 1'b1;
    porOk = 1'b1;
    addrSel = 1'b0;
    ext = 16'h1234;
    tgt = 7'h20;
    cyc(8);
    rst = 1'b0;
    cyc(4);
    chk(ioPinsOe, 16'h0000);
    rc(3'h2, 16'hffff);
    rc(3'h4, 16'h0000);
    rc(3'h6, 16'hffff);
    $display("test defaults done");
    wr(3'h3, 16'h5aa5);
    wr(3'h6, 16'hff00);
    chk(pu, 16'h005a);
    chk(pd, 16'h00a5);
    rc(3'h2, 16'ha55a);
    wr(3'h4, 16'hf000);
    rc(3'h0, 16'he25a);
    $display("test pins done");
    ext[12] = 1'b0;
    cyc(4);
    chk(alertLine, 1'b1);
    cyc(AC + 4);
    chk(alertLine, 1'b0);
    ext[12] = 1'b1;
    cyc(5);
    chk(alertLine, 1'b1);
    ext[12] = 1'b0;
    cyc(AC + 6);
    foreign();
    chk(alertLine, 1'b0);
    rc(3'h0, 16'hf25a);
    chk(alertLine, 1'b1);
    wr(3'h2, 16'h5a00);
    cyc(AC + 6);
    chk(alertLine, 1'b1);
    ext[12] = 1'b1;
    cyc(AC + 6);
    chk(alertLine, 1'b0);
    $display("test alert done");
    addrSel = 1'b1;
    tgt = 7'h21;
    rc(3'h6, 16'hff00);
    tgt = 7'h20;
    mst.start();
    tx({tgt, 1'b0}, 1'b1);
    mst.stop();
    tgt = 7'h21;
    $display("test address done");
    cyc(1);
    resetN = 1'b0;
    cyc(4);
    chk(ioPinsOe, 16'h0000);
    chk(alertLine, 1'b1);
    resetN = 1'b1;
    cyc(4);
    wr(3'h6, 16'h0000);
    porOk = 1'b0;
    cyc(4);
    chk(ioPinsOe, 16'h0000);
    porOk = 1'b1;
    cyc(4);
    rc(3'h2, 16'hffff);
    $display("test resets done");
    complete_run();
  end
  initial begin
    #500000;
    nFail++;
    complete_run();
  end
endmodule : i2c_io_expander_core_tb_top

// ==== dv/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  // Low phase longer than high: target data is resynchronised
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    #50 sdaLow = !b;
    #75 scl = 1'b1;
    #75 r = sdaLine;
    scl = 1'b0;
  endtask : bitx
  task automatic start();
    #50 sdaLow = 1'b0;
    #75 scl = 1'b1;
    #100 sdaLow = 1'b1;
    #100 scl = 1'b0;
  endtask : start
  task automatic stop();
    #50 sdaLow = 1'b1;
    #75 scl = 1'b1;
    #100 sdaLow = 1'b0;
    #100;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(nak, a);
  endtask : xfer
endmodule : i2c_master_model

// ==== dv/io_expander_chk.sv ====
`timescale 1ns/1ps
module io_expander_chk #(
  parameter int ALERT_CYCLES = 160
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [15:0] ioPinsIn,
  input wire logic [15:0] ioPinsOut,
  input wire logic [15:0] ioPinsOe,
  input wire logic [15:0] pullUpTransistor,
  input wire logic [15:0] pullDownTransistor,
  input wire logic alertNOut,
  input wire logic alertNOe
);
  logic [7:0] quietCnt_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Saturates so a long quiet spell never wraps
  always_ff @(posedge sys_clk) begin
    if (rst || $changed(ioPinsIn)) begin
      quietCnt_r <= 8'h00;
    end else if (quietCnt_r != 8'hff) begin
      quietCnt_r <= quietCnt_r + 8'h01;
    end
  end
  a_input_hiz: assert property (
    ((pullUpTransistor | pullDownTransistor) & ~ioPinsOe) == 16'h0000) else $error("input driven");
  a_pull_up: assert property (
    pullUpTransistor == (ioPinsOe & ioPinsOut)) else $error("pull-up wrong");
  a_pull_down: assert property (
    pullDownTransistor == (ioPinsOe & ~ioPinsOut)) else $error("pull-down wrong");
  a_open_drain: assert property (
    !alertNOut && !sdaOut) else $error("open-drain level high");
  a_reset_state: assert property (disable iff (1'b0) rst |=>
    ioPinsOe == 16'h0000 && ioPinsOut == 16'hffff && !alertNOe && !sdaOe) else $error("reset");
  a_output_quiet: assert property (
    $rose(alertNOe) |-> $past(ioPinsOe) != 16'hffff) else $error("alert from outputs");
  a_alert_delay: assert property (
    $rose(alertNOe) |-> quietCnt_r + 8'h01 >= ALERT_CYCLES) else $error("alert too early");
  a_ack_hold: assert property (
    $rose(sclIn) |=> $stable(sdaOe) [*4]) else $error("data moved in clock high");
  a_sda_move_low: assert property (
    $changed(sdaOe) |-> !$past(sclIn)) else $error("data moved after rise");
endmodule : io_expander_chk
bind i2c_io_expander_core io_expander_chk #(.ALERT_CYCLES(ALERT_CYCLES)) chk (
  .sys_clk(sys_clk), .rst(rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .ioPinsIn(ioPinsIn), .ioPinsOut(ioPinsOut), .ioPinsOe(ioPinsOe),
  .pullUpTransistor(pullUpTransistor), .pullDownTransistor(pullDownTransistor),
  .alertNOut(alertNOut), .alertNOe(alertNOe));

// ==== src/gpio_expander_pkg.sv ====
package gpio_expander_pkg;

  localparam int SYS_CLK_MHZ = 40;
  localparam int ALERT_VALID_DELAY_NS = 4000;
  localparam int ALERT_VALID_CYCLES = (ALERT_VALID_DELAY_NS * SYS_CLK_MHZ) / 1000;
  localparam int RESET_PULSE_WIDTH_NS = 4;
  localparam int RESET_PULSE_CYCLES = 1;

  localparam logic [5:0] TARGET_ADDR_BASE = 6'h10;

  localparam logic [2:0] CMD_INPUT_0 = 3'h0;
  localparam logic [2:0] CMD_INPUT_1 = 3'h1;
  localparam logic [2:0] CMD_OUTPUT_0 = 3'h2;
  localparam logic [2:0] CMD_OUTPUT_1 = 3'h3;
  localparam logic [2:0] CMD_POLARITY_0 = 3'h4;
  localparam logic [2:0] CMD_POLARITY_1 = 3'h5;
  localparam logic [2:0] CMD_CONFIG_0 = 3'h6;
  localparam logic [2:0] CMD_CONFIG_1 = 3'h7;

  localparam logic [15:0] OUTPUT_RESET = 16'hffff;
  localparam logic [15:0] POLARITY_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'hffff;
  localparam logic [2:0] POINTER_RESET = 3'h0;

  typedef struct packed {
    logic [15:0] outPort;
    logic [15:0] polarity;
    logic [15:0] dirCfg;
  } regs_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } bus_state_t;

endpackage : gpio_expander_pkg

// ==== src/i2c_io_expander_core.sv ====
`timescale 1ns/1ps
module i2c_io_expander_core #(
  parameter int ALERT_CYCLES = gpio_expander_pkg::ALERT_VALID_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic resetN,
  input wire logic powerOnThresholdOk,
  input wire logic addrSel,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [15:0] ioPinsIn,
  output logic [15:0] ioPinsOut,
  output logic [15:0] ioPinsOe,
  output logic [15:0] pullUpTransistor,
  output logic [15:0] pullDownTransistor,
  output logic alertNOut,
  output logic alertNOe
);

  // Two-flop synchronisers; the first stage feeds only the second
  logic [1:0] sclSync_r, sdaSync_r, rstnSync_r, porSync_r, addrSync_r;
  logic [15:0] pinsMeta_r, pins_r;
  logic sclDly_r, sdaDly_r;

  always_ff @(posedge sys_clk) begin
    if (clkEn) begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
      rstnSync_r <= {rstnSync_r[0], resetN};
      porSync_r <= {porSync_r[0], powerOnThresholdOk};
      // Select pin is held per transaction, so latency is harmless
      addrSync_r <= {addrSync_r[0], addrSel};
      pinsMeta_r <= ioPinsIn;
      pins_r <= pinsMeta_r;
      sclDly_r <= sclSync_r[1];
      sdaDly_r <= sdaSync_r[1];
    end
  end

  wire scl = sclSync_r[1];
  wire sda = sdaSync_r[1];
  // Pin reset and power-on reset act like the system reset
  wire coreRst = rst | ~rstnSync_r[1] | ~porSync_r[1];
  // Conditions from sampled transitions; glitch filtering left to the pad
  wire sclRise = scl & ~sclDly_r;
  wire sclFall = ~scl & sclDly_r;
  wire startCond = scl & sclDly_r & sdaDly_r & ~sda;
  wire stopCond = scl & sclDly_r & ~sdaDly_r & sda;

  gpio_expander_pkg::regs_t regs_r;
  gpio_expander_pkg::bus_state_t state_r;
  logic [2:0] ptr_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [3:0] bitCnt_r;
  logic rdMode_r;
  logic sdaLow_r;
  logic masterAck_r;
  logic [15:0] snap_r;
  logic [7:0] alertCnt_r;
  logic alert_r;

  function automatic logic [7:0] regRead(input logic [2:0] p,
                                         input gpio_expander_pkg::regs_t r,
                                         input logic [15:0] pv);
    logic [15:0] inVal;
    inVal = pv ^ r.polarity;
    case (p)
      gpio_expander_pkg::CMD_INPUT_0: regRead = inVal[7:0];
      gpio_expander_pkg::CMD_INPUT_1: regRead = inVal[15:8];
      gpio_expander_pkg::CMD_OUTPUT_0: regRead = r.outPort[7:0];
      gpio_expander_pkg::CMD_OUTPUT_1: regRead = r.outPort[15:8];
      gpio_expander_pkg::CMD_POLARITY_0: regRead = r.polarity[7:0];
      gpio_expander_pkg::CMD_POLARITY_1: regRead = r.polarity[15:8];
      gpio_expander_pkg::CMD_CONFIG_0: regRead = r.dirCfg[7:0];
      default: regRead = r.dirCfg[15:8];
    endcase
  endfunction : regRead

  wire [6:0] myAddr = {gpio_expander_pkg::TARGET_ADDR_BASE, addrSync_r[1]};
  wire addrMatch = (shift_r[7:1] == myAddr);
  wire [7:0] rdByte = regRead(ptr_r, regs_r, pins_r);
  // Registers pair up: next byte goes to the other half of the pair
  wire [2:0] ptrPair = {ptr_r[2:1], ~ptr_r[0]};
  wire byteDone = (bitCnt_r == 4'h8);

  // Serial target state machine
  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      state_r <= gpio_expander_pkg::ST_IDLE;
      sdaLow_r <= 1'b0;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rdMode_r <= 1'b0;
      masterAck_r <= 1'b0;
      ptr_r <= gpio_expander_pkg::POINTER_RESET;
    end else if (clkEn) begin
      if (startCond) begin
        state_r <= gpio_expander_pkg::ST_ADDR;
        bitCnt_r <= 4'h0;
        sdaLow_r <= 1'b0;
      end else if (stopCond) begin
        state_r <= gpio_expander_pkg::ST_IDLE;
        sdaLow_r <= 1'b0;
      end else begin
        case (state_r)
          gpio_expander_pkg::ST_ADDR, gpio_expander_pkg::ST_CMD,
          gpio_expander_pkg::ST_WR: begin
            if (sclRise && !byteDone) begin
              shift_r <= {shift_r[6:0], sda};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && byteDone) begin
              bitCnt_r <= 4'h0;
              if (state_r == gpio_expander_pkg::ST_ADDR) begin
                if (addrMatch) begin
                  sdaLow_r <= 1'b1;
                  rdMode_r <= shift_r[0];
                  state_r <= gpio_expander_pkg::ST_ACK_ADDR;
                end else begin
                  state_r <= gpio_expander_pkg::ST_IDLE;
                end
              end else if (state_r == gpio_expander_pkg::ST_CMD) begin
                ptr_r <= shift_r[2:0];
                sdaLow_r <= 1'b1;
                state_r <= gpio_expander_pkg::ST_ACK_CMD;
              end else begin
                ptr_r <= ptrPair;
                sdaLow_r <= 1'b1;
                state_r <= gpio_expander_pkg::ST_ACK_WR;
              end
            end
          end
          gpio_expander_pkg::ST_ACK_ADDR: begin
            if (sclFall) begin
              if (rdMode_r) begin
                tx_r <= rdByte;
                sdaLow_r <= ~rdByte[7];
                state_r <= gpio_expander_pkg::ST_RD;
              end else begin
                sdaLow_r <= 1'b0;
                state_r <= gpio_expander_pkg::ST_CMD;
              end
            end
          end
          gpio_expander_pkg::ST_ACK_CMD, gpio_expander_pkg::ST_ACK_WR: begin
            if (sclFall) begin
              sdaLow_r <= 1'b0;
              state_r <= gpio_expander_pkg::ST_WR;
            end
          end
          gpio_expander_pkg::ST_RD: begin
            if (sclFall) begin
              if (bitCnt_r == 4'h7) begin
                bitCnt_r <= 4'h0;
                sdaLow_r <= 1'b0;
                state_r <= gpio_expander_pkg::ST_ACK_RD;
              end else begin
                bitCnt_r <= bitCnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b0};
                sdaLow_r <= ~tx_r[6];
              end
            end
          end
          gpio_expander_pkg::ST_ACK_RD: begin
            if (sclRise) begin
              masterAck_r <= ~sda;
              ptr_r <= ptrPair;
            end else if (sclFall) begin
              if (masterAck_r) begin
                tx_r <= rdByte;
                sdaLow_r <= ~rdByte[7];
                state_r <= gpio_expander_pkg::ST_RD;
              end else begin
                sdaLow_r <= 1'b0;
                state_r <= gpio_expander_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            sdaLow_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register writes land on the byte's last falling edge, before its ACK
  wire wrStrobe = clkEn & ~startCond & ~stopCond & sclFall & byteDone
                  & (state_r == gpio_expander_pkg::ST_WR);

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      regs_r.outPort <= gpio_expander_pkg::OUTPUT_RESET;
      regs_r.polarity <= gpio_expander_pkg::POLARITY_RESET;
      regs_r.dirCfg <= gpio_expander_pkg::CONFIG_RESET;
    end else if (wrStrobe) begin
      case (ptr_r)
        gpio_expander_pkg::CMD_OUTPUT_0: regs_r.outPort[7:0] <= shift_r;
        gpio_expander_pkg::CMD_OUTPUT_1: regs_r.outPort[15:8] <= shift_r;
        gpio_expander_pkg::CMD_POLARITY_0: regs_r.polarity[7:0] <= shift_r;
        gpio_expander_pkg::CMD_POLARITY_1: regs_r.polarity[15:8] <= shift_r;
        gpio_expander_pkg::CMD_CONFIG_0: regs_r.dirCfg[7:0] <= shift_r;
        gpio_expander_pkg::CMD_CONFIG_1: regs_r.dirCfg[15:8] <= shift_r;
        default: regs_r.dirCfg <= regs_r.dirCfg;
      endcase
    end
  end

  // Change alert: compares inputs with the levels last read out.
  // Clearing re-snapshots the port at the ACK clock rise, so a change
  // while the byte shifts out can be absorbed; any later change shows again.
  wire rdAckRise = clkEn & ~startCond & ~stopCond & sclRise
                   & (state_r == gpio_expander_pkg::ST_ACK_RD);
  wire clrLow = rdAckRise & (ptr_r == gpio_expander_pkg::CMD_INPUT_0);
  wire clrHigh = rdAckRise & (ptr_r == gpio_expander_pkg::CMD_INPUT_1);
  // Output pins are masked out of the compare
  wire [15:0] changed = (pins_r ^ snap_r) & regs_r.dirCfg;
  wire anyChange = |changed;

  always_ff @(posedge sys_clk) begin
    if (coreRst) begin
      snap_r <= pins_r;
      alertCnt_r <= 8'h00;
      alert_r <= 1'b0;
    end else if (clkEn) begin
      if (clrLow) begin
        snap_r[7:0] <= pins_r[7:0];
      end
      if (clrHigh) begin
        snap_r[15:8] <= pins_r[15:8];
      end
      if (!anyChange || clrLow || clrHigh) begin
        alertCnt_r <= 8'h00;
        alert_r <= 1'b0;
      end else if (alertCnt_r == ALERT_CYCLES[7:0] - 8'h01) begin
        alert_r <= 1'b1;
      end else begin
        alertCnt_r <= alertCnt_r + 8'h01;
      end
    end
  end

  // Pin drivers
  assign ioPinsOe = ~regs_r.dirCfg;
  assign ioPinsOut = regs_r.outPort;
  assign pullUpTransistor = ~regs_r.dirCfg & regs_r.outPort;
  assign pullDownTransistor = ~regs_r.dirCfg & ~regs_r.outPort;

  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_r;
  assign alertNOut = 1'b0;
  assign alertNOe = alert_r;

endmodule : i2c_io_expander_core
